// [i2c_master_model.sv]
/*
  I2C bus master model for the control-register port, with SCL at eight system clocks.
  Assumes the bench resolves SDA as a wired-AND with a pull-up and keeps SCL high between frames.
*/
module i2c_master_model (
  // Clock
  input  wire logic clk_i,
  // Serial bus
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // SDA only moves while SCL is low, except in start and stop
  task automatic start();
    sda_o <= 1'b1;
    wt(2);
    scl_o <= 1'b1;
    wt(4);
    sda_o <= 1'b0;
    wt(4);
    scl_o <= 1'b0;
    wt(2);
  endtask
  // Long tail so the device has seen the stop before the next check
  task automatic stop();
    sda_o <= 1'b0;
    wt(2);
    scl_o <= 1'b1;
    wt(4);
    sda_o <= 1'b1;
    wt(8);
  endtask
  // Sample mid-high on a falling clock edge to stay clear of device updates
  task automatic bit_io(input logic b, output logic r);
    sda_o <= b;
    wt(2);
    scl_o <= 1'b1;
    wt(2);
    @(negedge clk_i);
    r = sda_i;
    wt(2);
    scl_o <= 1'b0;
    wt(2);
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Master acknowledge asks for another byte, no-acknowledge ends the read
  task automatic get(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!more, r);
  endtask
endmodule

// [nvsram_ctrl_pkg.sv]
/*
  Constants for the control-register port of the serial nonvolatile SRAM.
  Assumes a single 20 MHz clock domain; the serial bus pins are synchronised in the port module.
*/
package nvsram_ctrl_pkg;
  localparam logic [7:0] STATUS_ADDR  = 8'h00;
  localparam logic [7:0] COMMAND_ADDR = 8'h55;
  localparam logic [7:0] CMD_STORE    = 8'h33;
  localparam logic [7:0] CMD_RECALL   = 8'hDD;
  // Control-register op code of the slave address; value is arbitrary
  localparam logic [3:0] CTRL_OPCODE  = 4'h3;
  localparam int OPC_HI  = 7;
  localparam int OPC_LO  = 4;
  localparam int CS_HI   = 3;
  localparam int CS_LO   = 2;
  localparam int RW_BIT  = 0;
  localparam int MOD_BIT  = 7;
  localparam int PROT_HI  = 4;
  localparam int PROT_LO  = 2;
  localparam int AUTO_BIT = 1;
  localparam int EVT_BIT = 0;
  localparam logic       MOD_RST  = 1'h0;
  localparam logic [2:0] PROT_RST = 3'h0;
  localparam logic       AUTO_RST = 1'h0;
  localparam logic       EVT_RST = 1'h0;
  localparam logic [1:0] UNIMP   = 2'h0;
  localparam logic [1:0] KIND_CTRL = 2'h0;
  localparam logic [1:0] KIND_ADDR = 2'h1;
  localparam logic [1:0] KIND_DATA = 2'h2;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int CLK_NS = 50;
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_RX     = 6'h02,
    ST_ACK    = 6'h04,
    ST_TX     = 6'h08,
    ST_MACK   = 6'h10,
    ST_IGNORE = 6'h20
  } port_state_e;
endpackage

// [nvsram_ctrl_port.sv]
/*
  Control-register port: serial slave for the status and command registers.
  Assumes the serial clock is at least eight system clocks per period and that the
  store/recall engine reports completion on nv_done_i in this clock domain.
*/
module nvsram_ctrl_port #(
  parameter int WRITE_CYCLE_NS = 1000000
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Serial bus and chip select pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  input  wire logic       a1_i,
  input  wire logic       a2_i,
  // Store engine and array events
  input  wire logic       array_write_i,
  input  wire logic       hw_event_i,
  input  wire logic       ext_store_i,
  input  wire logic       nv_done_i,
  output logic            sw_store_o,
  output logic            sw_recall_o,
  output logic            status_commit_o,
  output logic            busy_o,
  // Configuration seen by the array
  output logic            array_modified_flag_o,
  output logic [2:0]      block_protect_field_o,
  output logic            auto_store_enable_o,
  output logic            event_flag_o
);
  localparam int WC_CYCLES = (WRITE_CYCLE_NS + nvsram_ctrl_pkg::CLK_NS - 1) / nvsram_ctrl_pkg::CLK_NS;
  localparam int WC_W = $clog2(WC_CYCLES + 1);

  typedef struct packed {
    nvsram_ctrl_pkg::port_state_e st;
    logic [1:0]      kind;
    logic [3:0]      cnt;
    logic [7:0]      sh;
    logic            rw;
    logic            to_cmd;
    logic            data_seen;
    logic            pend_stat;
    logic [7:0]      pend_val;
    logic            pend_store;
    logic            pend_recall;
    logic            modified;
    logic [2:0]      prot;
    logic            auto_en;
    logic            evt;
    logic            nv_busy;
    logic [WC_W-1:0] wc;
    logic            oe_n;
    logic            store_p;
    logic            recall_p;
    logic            commit_p;
    logic            scl0;
    logic            scl1;
    logic            scl2;
    logic            sda0;
    logic            sda1;
    logic            sda2;
    logic [1:0]      cs0;
    logic [1:0]      cs1;
  } port_s;

  port_s      r;
  port_s      next_r;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic       busy;
  logic [7:0] status_byte;

  assign rise  = r.scl1 & ~r.scl2;
  assign fall  = ~r.scl1 & r.scl2;
  assign start = r.scl1 & r.scl2 & r.sda2 & ~r.sda1;
  assign stop  = r.scl1 & r.scl2 & ~r.sda2 & r.sda1;
  assign busy  = r.nv_busy | (r.wc != '0);
  // Unimplemented bits are hard zeros
  assign status_byte = {r.modified, nvsram_ctrl_pkg::UNIMP, r.prot, r.auto_en, r.evt};

  always_comb begin
    next_r = r;
    next_r.scl0 = scl_i;
    next_r.scl1 = r.scl0;
    next_r.scl2 = r.scl1;
    next_r.sda0 = sda_i;
    next_r.sda1 = r.sda0;
    next_r.sda2 = r.sda1;
    next_r.cs0 = {a2_i, a1_i};
    next_r.cs1 = r.cs0;
    next_r.store_p = 1'h0;
    next_r.recall_p = 1'h0;
    next_r.commit_p = 1'h0;
    if (r.wc != '0) begin
      next_r.wc = r.wc - 1'h1;
    end
    // Completion first, so a store started in the same cycle keeps busy set
    if (nv_done_i) begin
      next_r.nv_busy = 1'h0;
      next_r.modified = 1'h0;
    end
    if (start) begin
      next_r.st = nvsram_ctrl_pkg::ST_RX;
      next_r.kind = nvsram_ctrl_pkg::KIND_CTRL;
      next_r.cnt = 4'h0;
      next_r.oe_n = 1'h1;
      next_r.data_seen = 1'h0;
      next_r.pend_stat = 1'h0;
      next_r.pend_store = 1'h0;
      next_r.pend_recall = 1'h0;
    end else if (stop) begin
      if (r.pend_stat) begin
        // Only writable bits take the last byte
        next_r.prot = r.pend_val[nvsram_ctrl_pkg::PROT_HI:nvsram_ctrl_pkg::PROT_LO];
        next_r.auto_en = r.pend_val[nvsram_ctrl_pkg::AUTO_BIT];
        next_r.evt = r.pend_val[nvsram_ctrl_pkg::EVT_BIT];
        next_r.commit_p = 1'h1;
        next_r.wc = WC_W'(WC_CYCLES);
      end
      if (r.pend_store) begin
        // Store ignores modified flag and auto-store enable
        next_r.store_p = 1'h1;
        next_r.nv_busy = 1'h1;
      end
      if (r.pend_recall) begin
        next_r.recall_p = 1'h1;
        next_r.nv_busy = 1'h1;
      end
      next_r.st = nvsram_ctrl_pkg::ST_IDLE;
      next_r.oe_n = 1'h1;
      next_r.pend_stat = 1'h0;
      next_r.pend_store = 1'h0;
      next_r.pend_recall = 1'h0;
    end else begin
      case (r.st)
        nvsram_ctrl_pkg::ST_RX: begin
          if (rise) begin
            next_r.sh = {r.sh[6:0], r.sda1};
            next_r.cnt = r.cnt + 4'h1;
          end else if (fall && r.cnt == nvsram_ctrl_pkg::BYTE_BITS) begin
            next_r.st = nvsram_ctrl_pkg::ST_ACK;
            next_r.oe_n = 1'h0;
            next_r.cnt = 4'h0;
            if (r.kind == nvsram_ctrl_pkg::KIND_CTRL) begin
              // Busy device answers nothing
              if (r.sh[nvsram_ctrl_pkg::OPC_HI:nvsram_ctrl_pkg::OPC_LO] != nvsram_ctrl_pkg::CTRL_OPCODE
                  || r.sh[nvsram_ctrl_pkg::CS_HI:nvsram_ctrl_pkg::CS_LO] != r.cs1 || busy) begin
                next_r.st = nvsram_ctrl_pkg::ST_IGNORE;
                next_r.oe_n = 1'h1;
              end
              next_r.rw = r.sh[nvsram_ctrl_pkg::RW_BIT];
            end else if (r.kind == nvsram_ctrl_pkg::KIND_ADDR) begin
              // Target chosen now, kept until the next address byte
              if (r.sh == nvsram_ctrl_pkg::STATUS_ADDR) begin
                next_r.to_cmd = 1'h0;
              end else if (r.sh == nvsram_ctrl_pkg::COMMAND_ADDR) begin
                next_r.to_cmd = 1'h1;
              end else begin
                next_r.st = nvsram_ctrl_pkg::ST_IGNORE;
                next_r.oe_n = 1'h1;
              end
            end else begin
              next_r.data_seen = 1'h1;
              if (!r.to_cmd) begin
                next_r.pend_stat = 1'h1;
                next_r.pend_val = r.sh;
              end else if (!r.data_seen && r.sh == nvsram_ctrl_pkg::CMD_STORE) begin
                next_r.pend_store = 1'h1;
              end else if (!r.data_seen && r.sh == nvsram_ctrl_pkg::CMD_RECALL) begin
                next_r.pend_recall = 1'h1;
              end else begin
                // Bad or second command byte aborts
                next_r.st = nvsram_ctrl_pkg::ST_IGNORE;
                next_r.oe_n = 1'h1;
                next_r.pend_store = 1'h0;
                next_r.pend_recall = 1'h0;
              end
            end
          end
        end
        nvsram_ctrl_pkg::ST_ACK: begin
          if (fall) begin
            if (r.rw) begin
              next_r.st = nvsram_ctrl_pkg::ST_TX;
              next_r.sh = status_byte;
              next_r.oe_n = status_byte[nvsram_ctrl_pkg::MOD_BIT];
              next_r.cnt = 4'h1;
            end else begin
              next_r.st = nvsram_ctrl_pkg::ST_RX;
              next_r.oe_n = 1'h1;
              next_r.kind = (r.kind == nvsram_ctrl_pkg::KIND_CTRL) ? nvsram_ctrl_pkg::KIND_ADDR
                                                                    : nvsram_ctrl_pkg::KIND_DATA;
            end
          end
        end
        nvsram_ctrl_pkg::ST_TX: begin
          if (fall) begin
            if (r.cnt == nvsram_ctrl_pkg::BYTE_BITS) begin
              next_r.st = nvsram_ctrl_pkg::ST_MACK;
              next_r.oe_n = 1'h1;
            end else begin
              next_r.sh = {r.sh[6:0], 1'h0};
              next_r.oe_n = r.sh[6];
              next_r.cnt = r.cnt + 4'h1;
            end
          end
        end
        nvsram_ctrl_pkg::ST_MACK: begin
          if (rise && r.sda1) begin
            next_r.st = nvsram_ctrl_pkg::ST_IGNORE;
          end else if (fall) begin
            next_r.st = nvsram_ctrl_pkg::ST_TX;
            next_r.sh = status_byte;
            next_r.oe_n = status_byte[nvsram_ctrl_pkg::MOD_BIT];
            next_r.cnt = 4'h1;
          end
        end
        default: begin
        end
      endcase
    end
    if (ext_store_i) begin
      // Store cannot wait for the bus, so the register access is dropped
      next_r.st = nvsram_ctrl_pkg::ST_IGNORE;
      next_r.oe_n = 1'h1;
      next_r.pend_stat = 1'h0;
      next_r.pend_store = 1'h0;
      next_r.pend_recall = 1'h0;
      next_r.nv_busy = 1'h1;
    end
    // Sets come last so an event in a clearing cycle survives
    if (array_write_i) begin
      next_r.modified = 1'h1;
    end
    if (hw_event_i) begin
      next_r.evt = 1'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r <= '0;
      r.st <= nvsram_ctrl_pkg::ST_IDLE;
      r.oe_n <= 1'h1;
      r.scl0 <= 1'h1;
      r.scl1 <= 1'h1;
      r.scl2 <= 1'h1;
      r.sda0 <= 1'h1;
      r.sda1 <= 1'h1;
      r.sda2 <= 1'h1;
      r.modified <= nvsram_ctrl_pkg::MOD_RST;
      r.prot <= nvsram_ctrl_pkg::PROT_RST;
      r.auto_en <= nvsram_ctrl_pkg::AUTO_RST;
      r.evt <= nvsram_ctrl_pkg::EVT_RST;
    end else begin
      r <= next_r;
    end
  end

  // Open drain: only ever pulls low
  assign sda_o = 1'h0;
  assign sda_oe_n_o = r.oe_n;
  assign sw_store_o = r.store_p;
  assign sw_recall_o = r.recall_p;
  assign status_commit_o = r.commit_p;
  assign busy_o = busy;
  assign array_modified_flag_o = r.modified;
  assign block_protect_field_o = r.prot;
  assign auto_store_enable_o = r.auto_en;
  assign event_flag_o = r.evt;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence stop_with_status;
    stop && r.pend_stat && !ext_store_i;
  endsequence

  sequence stop_with_store;
    stop && r.pend_store && !ext_store_i;
  endsequence

  sequence master_nack;
    r.st == nvsram_ctrl_pkg::ST_MACK && rise && r.sda1 && !start && !stop;
  endsequence

  status_commit_a: assert property (
    stop_with_status ##0 (!array_write_i && !nv_done_i) |=> status_commit_o && $stable(r.modified)
      && r.prot == $past(r.pend_val[nvsram_ctrl_pkg::PROT_HI:nvsram_ctrl_pkg::PROT_LO])
      && (r.wc == WC_W'(WC_CYCLES)))
    else $error("status write did not commit its writable bits");

  store_start_a: assert property (
    stop_with_store |=> sw_store_o && busy_o ##1 !sw_store_o)
    else $error("software store did not start");

  busy_silent_a: assert property (
    busy_o |-> sda_oe_n_o)
    else $error("acknowledge driven while busy");

  done_clears_a: assert property (
    nv_done_i && !array_write_i && !ext_store_i && !stop |=> !array_modified_flag_o && !r.nv_busy)
    else $error("completion did not clear modified flag");

  array_write_a: assert property (
    array_write_i |=> array_modified_flag_o)
    else $error("array write did not set modified flag");

  event_set_a: assert property (
    hw_event_i |=> event_flag_o)
    else $error("pin event not recorded");

  ext_abort_a: assert property (
    ext_store_i |=> r.st == nvsram_ctrl_pkg::ST_IGNORE && sda_oe_n_o && !r.pend_stat)
    else $error("register access not abandoned");

  read_end_a: assert property (
    master_nack ##0 !ext_store_i |=> r.st == nvsram_ctrl_pkg::ST_IGNORE ##1 sda_oe_n_o)
    else $error("read continued after master no-ack");

  read_load_a: assert property (
    $rose(r.st == nvsram_ctrl_pkg::ST_TX) |-> r.sh[6:5] == nvsram_ctrl_pkg::UNIMP
      && r.sh[nvsram_ctrl_pkg::MOD_BIT] == $past(r.modified))
    else $error("status byte loaded wrongly");

  bad_addr_a: assert property (
    r.st == nvsram_ctrl_pkg::ST_RX && r.kind == nvsram_ctrl_pkg::KIND_ADDR && fall
      && r.cnt == nvsram_ctrl_pkg::BYTE_BITS && r.sh != nvsram_ctrl_pkg::STATUS_ADDR
      && r.sh != nvsram_ctrl_pkg::COMMAND_ADDR && !start && !stop
      |=> r.st == nvsram_ctrl_pkg::ST_IGNORE && sda_oe_n_o)
    else $error("unknown address acknowledged");
endmodule

// [nvsram_ctrl_port_tb.sv]
/*
  Self-checking bench for the control-register port: status and command writes and reads.
  Assumes the design package and the I2C master model are compiled before it.
*/
module nvsram_ctrl_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [3:0] ev = 4'h0;
  logic [3:0] ak;
  logic       a;
  int         err_count = 0;
  int         check_count = 0;
  int         n_store = 0;
  int         n_recall = 0;
  int         n_commit = 0;
  wire        scl, m_sda, sda_o, sda_oe_n, busy, mod_flag, auto_en, evt, st, rc, cm;
  wire  [2:0] prot;
  wire        sda = m_sda & (sda_oe_n | sda_o);
  initial forever #25 clk = ~clk;
  i2c_master_model i2c_master_model_i (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(m_sda));
  // Short write cycle keeps the run brief
  nvsram_ctrl_port #(.WRITE_CYCLE_NS(10000)) nvsram_ctrl_port_i (
    .clk_i(clk), .reset_i(reset), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
    .a1_i(1'b0), .a2_i(1'b1), .array_write_i(ev[0]), .hw_event_i(ev[1]), .ext_store_i(ev[2]),
    .nv_done_i(ev[3]), .sw_store_o(st), .sw_recall_o(rc), .status_commit_o(cm), .busy_o(busy),
    .array_modified_flag_o(mod_flag), .block_protect_field_o(prot), .auto_store_enable_o(auto_en),
    .event_flag_o(evt));
  always @(posedge clk) begin
    n_store <= n_store + int'(st === 1'b1);
    n_recall <= n_recall + int'(rc === 1'b1);
    n_commit <= n_commit + int'(cm === 1'b1);
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [7:0] cb(input logic rw);
    return {nvsram_ctrl_pkg::CTRL_OPCODE, 2'b10, 1'b0, rw};
  endfunction
  task automatic pulse(input logic [3:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 4'h0;
    @(posedge clk);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 400; i++) begin
      if (busy === 1'b0) return;
      @(posedge clk);
    end
    err_count++;
    close_out();
  endtask
  task automatic wr(input logic [23:0] b, input int n, output logic [3:0] k);
    logic r;
    k = 4'h0;
    i2c_master_model_i.start();
    i2c_master_model_i.put(cb(1'b0), r);
    k[0] = r;
    for (int i = 0; i < n; i++) begin
      i2c_master_model_i.put(b[23-8*i -: 8], r);
      k[i+1] = r;
    end
    i2c_master_model_i.stop();
  endtask
  task automatic rd(input int n, input logic [7:0] exp);
    logic       r;
    logic [7:0] d;
    i2c_master_model_i.start();
    i2c_master_model_i.put(cb(1'b1), r);
    check({7'h0, r}, 8'h01);
    for (int i = n; i > 0; i--) begin
      i2c_master_model_i.get(i > 1, d);
      check(d, exp);
    end
    i2c_master_model_i.stop();
  endtask
  task automatic probe(output logic r);
    i2c_master_model_i.start();
    i2c_master_model_i.put(cb(1'b0), r);
    i2c_master_model_i.stop();
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    rd(1, 8'h00);
    // Ones offered to read-only bits must not land
    wr({8'h00, 8'h55, 8'hFE}, 3, ak);
    check({4'h0, ak}, 8'h0F);
    check(8'(n_commit), 8'h01);
    probe(a);
    check({7'h0, a}, 8'h00);
    wait_idle();
    rd(1, 8'h1E);
    $display("status write test done");
    for (int k = 0; k < 8; k++) begin
      wr({8'h00, 3'h0, k[2:0], k[0], 1'b0, 8'h00}, 2, ak);
      wait_idle();
      check({5'h0, prot}, 8'(k));
      check({7'h0, auto_en}, {7'h0, k[0]});
      rd(1, {3'h0, k[2:0], k[0], 1'b0});
    end
    $display("protect field test done");
    pulse(4'h3);
    check({6'h0, mod_flag, evt}, 8'h03);
    rd(2, 8'h9F);
    $display("flag test done");
    for (int k = 0; k < 2; k++) begin
      pulse(4'h1);
      wr({8'h55, k ? nvsram_ctrl_pkg::CMD_RECALL : nvsram_ctrl_pkg::CMD_STORE, 8'h00}, 2, ak);
      check({4'h0, ak}, 8'h07);
      check({8'(n_store), 8'(n_recall)}, {8'h01, 8'(k)});
      probe(a);
      check({6'h0, a, mod_flag}, 8'h01);
      pulse(4'h8);
      check({6'h0, busy, mod_flag}, 8'h00);
    end
    $display("command test done");
    wr({8'h12, 8'h00, 8'h00}, 2, ak);
    check({4'h0, ak}, 8'h01);
    wr({8'h55, 8'h44, 8'h00}, 2, ak);
    check({4'h0, ak}, 8'h03);
    wr({8'h33, 8'h00, 8'h00}, 1, ak);
    check({4'h0, ak}, 8'h01);
    wr({8'h55, nvsram_ctrl_pkg::CMD_STORE, nvsram_ctrl_pkg::CMD_STORE}, 3, ak);
    check({4'h0, ak}, 8'h07);
    check({7'(n_store), busy}, 8'h02);
    $display("refusal test done");
    // Store from outside cuts the status write short
    i2c_master_model_i.start();
    i2c_master_model_i.put(cb(1'b0), a);
    i2c_master_model_i.put(8'h00, a);
    pulse(4'h4);
    i2c_master_model_i.put(8'h00, a);
    check({7'h0, a}, 8'h00);
    i2c_master_model_i.stop();
    check({7'h0, busy}, 8'h01);
    pulse(4'h8);
    rd(1, 8'h1F);
    $display("abort test done");
    close_out();
  end
endmodule
